// ===== hdl/cws_map.svh
// Offsets, field positions, reset values and layout constants of the window
`ifndef CWS_MAP_SVH
`define CWS_MAP_SVH
`define CWS_ADR_STA    8'hd8
`define CWS_ADR_CON    8'hd9
`define CWS_ADR_DAT    8'hda
`define CWS_ADR_PTR    8'hdb
`define CWS_BIT_BASE   8'hd8
`define CWS_BIT_TOP    8'hdf
`define CWS_PTR_RESET  8'h64
`define CWS_PTR_DMA    7
`define CWS_PTR_RSVD   6
`define CWS_PTR_AUTO   5
`define CWS_SEL_W      5
`define CWS_INT_W      5
`define CWS_INT_RSVD   8'he0
`define CWS_UNMAPPED   8'hff
`define CWS_TX_BASE    5'h0a
`define CWS_RX_BASE    5'h14
`define CWS_DSC2_OFS   5'h01
`define CWS_DATA_OFS   5'h02
`define CWS_RTR_BIT    4
`define CWS_DLC_MAX    4'h8
`endif

// ===== hdl/cws_pkg.sv
// Types and shared decode functions of the CPU to CAN register window
`include "cws_map.svh"
package cws_pkg;
  typedef logic [7:0] cws_byte_t;
  typedef logic [`CWS_SEL_W-1:0] cws_sel_t;
  typedef enum logic [2:0] {
    CWS_NONE, CWS_STA, CWS_CON, CWS_DAT, CWS_PTR
  } cws_sfr_t;

  function automatic cws_sfr_t cws_decode(input cws_byte_t a);
    unique case (a)
      `CWS_ADR_STA: cws_decode = CWS_STA;
      `CWS_ADR_CON: cws_decode = CWS_CON;
      `CWS_ADR_DAT: cws_decode = CWS_DAT;
      `CWS_ADR_PTR: cws_decode = CWS_PTR;
      default:      cws_decode = CWS_NONE;
    endcase
  endfunction : cws_decode

  // Byte count from the second descriptor byte; remote frames carry none
  function automatic logic [3:0] cws_count(input cws_byte_t d);
    if (d[`CWS_RTR_BIT])
      cws_count = 4'h0;
    else if (d[3:0] > `CWS_DLC_MAX)
      cws_count = `CWS_DLC_MAX;
    else
      cws_count = d[3:0];
  endfunction : cws_count
endpackage : cws_pkg

// ===== hdl/cws_win_if.sv
// Signals shared between the window top, the pointer and the layout tracker
`timescale 1ns/1ps
`default_nettype none
interface cws_win_if;
  import cws_pkg::*;
  logic      ptr_wr;
  cws_byte_t wdata;
  logic      win_acc;
  logic      win_wr;
  cws_byte_t rsnoop;
  logic      dma_done;
  cws_byte_t ptr_q;
  logic [3:0] tx_count;
  logic [3:0] rx_count;
  cws_sel_t  tx_end;
  cws_sel_t  rx_end;
  modport top (output ptr_wr, wdata, win_acc, win_wr, rsnoop, dma_done,
               input ptr_q, tx_count, rx_count, tx_end, rx_end);
  modport ptr (input ptr_wr, wdata, win_acc, dma_done, output ptr_q);
  modport lay (input win_acc, win_wr, wdata, rsnoop, ptr_q,
               output tx_count, rx_count, tx_end, rx_end);
endinterface : cws_win_if
`default_nettype wire

// ===== hdl/cws_pointer.sv
// Register pointer with DMA start and auto-step bits
`timescale 1ns/1ps
`default_nettype none
`include "cws_map.svh"
module cws_pointer
  import cws_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  cws_win_if.ptr    win
);
  cws_byte_t ptr;
  cws_byte_t next_ptr;

  always_comb begin
    next_ptr = ptr;
    if (win.ptr_wr) begin
      next_ptr = win.wdata;
    end else if (win.win_acc && ptr[`CWS_PTR_AUTO]) begin
      // Step the select field only; passing the top clears auto-step
      next_ptr[`CWS_SEL_W-1:0] = ptr[`CWS_SEL_W-1:0] + 5'h01;
      if (&ptr[`CWS_SEL_W-1:0])
        next_ptr[`CWS_PTR_AUTO] = 1'b0;
    end
    // A fresh write of the DMA bit wins over a completion in the same cycle
    if (win.dma_done && !win.ptr_wr)
      next_ptr[`CWS_PTR_DMA] = 1'b0;
    next_ptr[`CWS_PTR_RSVD] = 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i)
      ptr <= `CWS_PTR_RESET;
    else
      ptr <= next_ptr;
  end

  assign win.ptr_q = ptr;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  ptr_step_a: assert property (
    win.win_acc && !win.ptr_wr && ptr[`CWS_PTR_AUTO]
    |=> ptr[4:0] == $past(ptr[4:0]) + 5'h01)
    else $error("pointer did not step after window access");
  ptr_dma_clr_a: assert property (
    win.dma_done && !win.ptr_wr |=> !ptr[`CWS_PTR_DMA])
    else $error("DMA bit not cleared on completion");
endmodule : cws_pointer
`default_nettype wire

// ===== hdl/cws_layout.sv
// Tracks transmit and receive descriptors seen through the window
`timescale 1ns/1ps
`default_nettype none
`include "cws_map.svh"
module cws_layout
  import cws_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  cws_win_if.lay    win
);
  logic [3:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  cws_byte_t  dsc;
  cws_sel_t   sel;

  always_comb begin
    sel         = win.ptr_q[`CWS_SEL_W-1:0];
    dsc         = win.win_wr ? win.wdata : win.rsnoop;
    next_tx_cnt = tx_cnt;
    next_rx_cnt = rx_cnt;
    if (win.win_acc && sel == `CWS_TX_BASE + `CWS_DSC2_OFS)
      next_tx_cnt = cws_count(dsc);
    // Receive buffer shares the transmit layout, shifted up
    if (win.win_acc && sel == `CWS_RX_BASE + `CWS_DSC2_OFS)
      next_rx_cnt = cws_count(dsc);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_cnt <= 4'h0;
      rx_cnt <= 4'h0;
    end else begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
    end
  end

  // Data field starts two bytes past each base; end is that plus the count
  assign win.tx_count = tx_cnt;
  assign win.rx_count = rx_cnt;
  assign win.tx_end = `CWS_TX_BASE + `CWS_DATA_OFS + {1'b0, tx_cnt};
  assign win.rx_end = `CWS_RX_BASE + `CWS_DATA_OFS + {1'b0, rx_cnt};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  tx_count_max_a: assert property (tx_cnt <= `CWS_DLC_MAX)
    else $error("transmit byte count above eight");
endmodule : cws_layout
`default_nettype wire

// ===== hdl/cws_window.sv
// Special function register window between the CPU core and the CAN block
`timescale 1ns/1ps
`default_nettype none
`include "cws_map.svh"
// Function
// - Length code sizes data; data starts at 12
// - Receive buffer mirrors transmit layout from 20
// - Reserved bits of the pointer and interrupt flag registers read one
// - CPU reaches controller only through four registers
// - Pointer at DBH read/write, low five select
// - Reset loads pointer with 64H
// - Pointer bit 7 starts the DMA logic
// - Pointer bit 5 enables auto-step; bit 6 reserved
// - Window at DAH reads/writes selected register
// - Reading D9H returns controller interrupt flags
// - Writing D9H issues controller command byte
// - Status register byte and bit addressable
// - Reading status register returns controller status
// - Status write holds next DMA RAM address
// - Auto-step advances pointer after each window access
// - DMA bit clears after successful transfer
// - Byte count is binary length code, 0-8
module cws_window
  import cws_pkg::*;
#(
  parameter int SEL_W = `CWS_SEL_W
)(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic                 sfr_rd_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic                 sfr_bit_wr_i,
  input  wire logic [7:0]           sfr_bit_addr_i,
  input  wire logic                 sfr_bit_val_i,
  output logic      [7:0]           sfr_rdata_o,
  output logic                      sfr_rvalid_o,
  output logic      [SEL_W-1:0]     ctl_sel_o,
  input  wire logic [7:0]           ctl_rdata_i,
  output logic                      ctl_rd_o,
  output logic                      ctl_wr_o,
  output logic      [SEL_W-1:0]     ctl_waddr_o,
  output logic      [7:0]           ctl_wdata_o,
  input  wire logic [4:0]           ctl_int_i,
  input  wire logic [7:0]           ctl_status_i,
  output logic                      cmd_wr_o,
  output logic      [7:0]           cmd_o,
  output logic                      dma_start_o,
  output logic                      dma_autostep_o,
  output logic      [7:0]           dma_ram_pointer_o,
  input  wire logic                 dma_done_i,
  output logic      [3:0]           tx_count_o,
  output logic      [3:0]           rx_count_o,
  output logic      [SEL_W-1:0]     tx_end_o,
  output logic      [SEL_W-1:0]     rx_end_o
);
  // The select field, decode and layout math are built for five bits
  if (SEL_W != `CWS_SEL_W) begin : g_sel_check
    $error("cws_window: select width must be five bits");
  end

  cws_win_if win ();

  cws_pointer u_pointer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .win       (win.ptr)
  );

  cws_layout u_layout (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .win       (win.lay)
  );

  cws_sfr_t  rd_hit, wr_hit;
  cws_byte_t rdata, next_rdata;
  logic      rvalid, next_rvalid;
  logic      c_rd, next_c_rd, c_wr, next_c_wr;
  cws_sel_t  c_waddr, next_c_waddr;
  cws_byte_t c_wdata, next_c_wdata;
  logic      k_wr, next_k_wr;
  cws_byte_t k_cmd, next_k_cmd;
  cws_byte_t ram_ptr, next_ram_ptr;
  logic [3:0] tx_cnt, rx_cnt;
  cws_sel_t  tx_end, rx_end;

  // Every byte access into the controller goes through these four decodes; bit writes at D8H..DFH bypass them
  always_comb begin
    rd_hit = sfr_rd_i ? cws_decode(sfr_addr_i) : CWS_NONE;
    wr_hit = sfr_wr_i ? cws_decode(sfr_addr_i) : CWS_NONE;
  end

  assign win.ptr_wr   = (wr_hit == CWS_PTR);
  assign win.wdata    = sfr_wdata_i;
  assign win.win_acc  = (rd_hit == CWS_DAT) || (wr_hit == CWS_DAT);
  assign win.win_wr   = (wr_hit == CWS_DAT);
  assign win.rsnoop   = ctl_rdata_i;
  assign win.dma_done = dma_done_i;

  // Read path: registered byte one cycle after the strobe
  always_comb begin
    next_rdata  = rdata;
    next_rvalid = sfr_rd_i;
    unique case (rd_hit)
      CWS_PTR: next_rdata = win.ptr_q;
      CWS_DAT: next_rdata = ctl_rdata_i;
      CWS_CON: next_rdata = `CWS_INT_RSVD | {3'h0, ctl_int_i};
      CWS_STA: next_rdata = ctl_status_i;
      CWS_NONE: begin
        if (sfr_rd_i)
          next_rdata = `CWS_UNMAPPED;
      end
    endcase
  end

  // Window writes land at the select the pointer held when issued
  always_comb begin
    next_c_rd    = (rd_hit == CWS_DAT);
    next_c_wr    = (wr_hit == CWS_DAT);
    next_c_waddr = c_waddr;
    next_c_wdata = c_wdata;
    if (wr_hit == CWS_DAT) begin
      next_c_waddr = win.ptr_q[`CWS_SEL_W-1:0];
      next_c_wdata = sfr_wdata_i;
    end
  end

  // Command byte is write-only; reads of the same address see flags
  always_comb begin
    next_k_wr  = (wr_hit == CWS_CON);
    next_k_cmd = (wr_hit == CWS_CON) ? sfr_wdata_i : k_cmd;
  end

  // DMA RAM pointer: byte writes, or single bits at D8H..DFH
  always_comb begin
    next_ram_ptr = ram_ptr;
    if (wr_hit == CWS_STA)
      next_ram_ptr = sfr_wdata_i;
    if (sfr_bit_wr_i && sfr_bit_addr_i >= `CWS_BIT_BASE
        && sfr_bit_addr_i <= `CWS_BIT_TOP)
      next_ram_ptr[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata   <= 8'h00;
      rvalid  <= 1'b0;
      c_rd    <= 1'b0;
      c_wr    <= 1'b0;
      c_waddr <= 5'h00;
      c_wdata <= 8'h00;
      k_wr    <= 1'b0;
      k_cmd   <= 8'h00;
      ram_ptr <= 8'h00;
      tx_cnt  <= 4'h0;
      rx_cnt  <= 4'h0;
      tx_end  <= 5'h00;
      rx_end  <= 5'h00;
    end else begin
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
      c_rd    <= next_c_rd;
      c_wr    <= next_c_wr;
      c_waddr <= next_c_waddr;
      c_wdata <= next_c_wdata;
      k_wr    <= next_k_wr;
      k_cmd   <= next_k_cmd;
      ram_ptr <= next_ram_ptr;
      tx_cnt  <= win.tx_count;
      rx_cnt  <= win.rx_count;
      tx_end  <= win.tx_end;
      rx_end  <= win.rx_end;
    end
  end

  assign sfr_rdata_o       = rdata;
  assign sfr_rvalid_o      = rvalid;
  assign ctl_sel_o         = win.ptr_q[`CWS_SEL_W-1:0];
  assign ctl_rd_o          = c_rd;
  assign ctl_wr_o          = c_wr;
  assign ctl_waddr_o       = c_waddr;
  assign ctl_wdata_o       = c_wdata;
  assign cmd_wr_o          = k_wr;
  assign cmd_o             = k_cmd;
  assign dma_start_o       = win.ptr_q[`CWS_PTR_DMA];
  assign dma_autostep_o    = win.ptr_q[`CWS_PTR_AUTO];
  assign dma_ram_pointer_o = ram_ptr;
  assign tx_count_o        = tx_cnt;
  assign rx_count_o        = rx_cnt;
  assign tx_end_o          = tx_end;
  assign rx_end_o          = rx_end;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence ptr_write_s;
    sfr_wr_i && sfr_addr_i == `CWS_ADR_PTR && !sfr_rd_i;
  endsequence
  sequence ptr_read_s;
    sfr_rd_i && sfr_addr_i == `CWS_ADR_PTR;
  endsequence

  ptr_readback_a: assert property (
    ptr_write_s ##1 ptr_read_s |=> sfr_rdata_o[6] &&
      sfr_rdata_o[4:0] == $past(sfr_wdata_i[4:0], 2) && sfr_rvalid_o)
    else $error("pointer read-back differs from written value");
  int_rsvd_a: assert property (
    sfr_rd_i && sfr_addr_i == `CWS_ADR_CON
    |=> sfr_rdata_o[7:5] == 3'h7 && sfr_rdata_o[4:0] == $past(ctl_int_i))
    else $error("interrupt read wrong or reserved bits low");
  status_read_a: assert property (
    sfr_rd_i && sfr_addr_i == `CWS_ADR_STA
    |=> sfr_rdata_o == $past(ctl_status_i))
    else $error("status read does not match controller");
  cmd_issue_a: assert property (
    sfr_wr_i && sfr_addr_i == `CWS_ADR_CON
    |=> cmd_wr_o && cmd_o == $past(sfr_wdata_i)
    ##1 cmd_wr_o == $past(sfr_wr_i && sfr_addr_i == `CWS_ADR_CON))
    else $error("command byte not issued");
  win_write_a: assert property (
    sfr_wr_i && sfr_addr_i == `CWS_ADR_DAT
    |=> ctl_wr_o && ctl_wdata_o == $past(sfr_wdata_i)
        && ctl_waddr_o == $past(ctl_sel_o))
    else $error("window write not forwarded to selected register");
  ram_ptr_a: assert property (
    sfr_wr_i && sfr_addr_i == `CWS_ADR_STA && !sfr_bit_wr_i
    |=> dma_ram_pointer_o == $past(sfr_wdata_i))
    else $error("DMA RAM address not held");
  dma_start_a: assert property (
    ptr_write_s and (sfr_wdata_i[7] && !dma_done_i) |=> dma_start_o)
    else $error("DMA start bit not set by pointer write");

  // Window side effects: one pulse per strobe, data as sampled
  sequence win_rd_s;
    sfr_rd_i && sfr_addr_i == `CWS_ADR_DAT;
  endsequence
  sequence win_wr_s;
    sfr_wr_i && sfr_addr_i == `CWS_ADR_DAT;
  endsequence

  rvalid_pulse_a: assert property (
    sfr_rvalid_o == $past(sfr_rd_i))
    else $error("read valid does not follow the read strobe");
  ctl_strobe_a: assert property (
    ctl_rd_o == $past(sfr_rd_i && sfr_addr_i == `CWS_ADR_DAT)
    && ctl_wr_o == $past(sfr_wr_i && sfr_addr_i == `CWS_ADR_DAT))
    else $error("controller strobe without a window access");
  win_read_a: assert property (
    win_rd_s |=> sfr_rdata_o == $past(ctl_rdata_i))
    else $error("window read did not return the selected register");
  rdata_hold_a: assert property (
    !sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read byte changed without a read");

  // Auto-step: plain step below the top, wrap and disarm at the top
  win_step_a: assert property (
    (win_rd_s or win_wr_s) ##0 (dma_autostep_o && ctl_sel_o != 5'h1f)
    |=> ctl_sel_o == $past(ctl_sel_o) + 5'h01 && dma_autostep_o)
    else $error("auto-step did not advance the select");
  win_wrap_a: assert property (
    (win_rd_s or win_wr_s) ##0 (dma_autostep_o && ctl_sel_o == 5'h1f)
    |=> ctl_sel_o == 5'h00 && !dma_autostep_o)
    else $error("select wrap did not clear auto-step");
  no_step_a: assert property (
    (win_rd_s or win_wr_s) ##0 !dma_autostep_o |=> $stable(ctl_sel_o))
    else $error("select moved with auto-step off");

  // Pointer fields and the reserved bit
  sel_load_a: assert property (
    ptr_write_s |=> ctl_sel_o == $past(sfr_wdata_i[4:0])
      && dma_autostep_o == $past(sfr_wdata_i[5]))
    else $error("pointer write did not load select and auto-step");
  ptr_rsvd_a: assert property (
    ptr_read_s |=> sfr_rdata_o[6])
    else $error("reserved pointer bit read low");

  // Unmapped bytes answer all ones and leave every register alone
  unmapped_rd_a: assert property (
    sfr_rd_i && cws_decode(sfr_addr_i) == CWS_NONE
    |=> sfr_rdata_o == `CWS_UNMAPPED)
    else $error("unmapped read did not return all ones");
  unmapped_wr_a: assert property (
    sfr_wr_i && cws_decode(sfr_addr_i) == CWS_NONE && !sfr_bit_wr_i
    |=> !ctl_wr_o && !cmd_wr_o && $stable(ctl_sel_o)
        && $stable(dma_ram_pointer_o))
    else $error("unmapped write reached a register");

  // DMA RAM address bits reached one at a time
  ram_bit_a: assert property (
    sfr_bit_wr_i && sfr_bit_addr_i >= `CWS_BIT_BASE
    && sfr_bit_addr_i <= `CWS_BIT_TOP
    |=> dma_ram_pointer_o[$past(sfr_bit_addr_i[2:0])]
        == $past(sfr_bit_val_i))
    else $error("bit write missed the DMA RAM address");

  cmd_hold_a: assert property (
    !(sfr_wr_i && sfr_addr_i == `CWS_ADR_CON) |=> $stable(cmd_o))
    else $error("command byte changed without a write");
  dma_hold_a: assert property (
    !(sfr_wr_i && sfr_addr_i == `CWS_ADR_PTR) && !dma_done_i
    |=> $stable(dma_start_o))
    else $error("DMA start bit moved without cause");
  count_max_a: assert property (
    tx_count_o <= `CWS_DLC_MAX && rx_count_o <= `CWS_DLC_MAX)
    else $error("byte count above eight");
endmodule : cws_window
`default_nettype wire

// ===== dv/cws_ctl_model.sv
// Controller register file and DMA responder beside the window
`timescale 1ns/1ps
`default_nettype none
module cws_ctl_model (
  input  wire logic       clk_sys_i,
  input  wire logic [4:0] sel_i,
  output logic      [7:0] rdata_o,
  input  wire logic       wr_i,
  input  wire logic [4:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       dma_start_i,
  input  wire logic [4:0] dma_lat_i,
  output logic            dma_done_o
);
  logic [7:0] mem [32];
  logic [5:0] cnt;
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'(i) ^ 8'h5a;
    cnt = '0;
    dma_done_o = 1'b0;
  end
  // Combinational read: the window samples it in the strobe cycle
  assign rdata_o = mem[sel_i];
  // Done pulses once per start; latency set by the bench, prompt or slow
  always @(posedge clk_sys_i) begin
    if (wr_i) mem[waddr_i] <= wdata_i;
    dma_done_o <= 1'b0;
    if (!dma_start_i) cnt <= '0;
    else if (cnt == {1'b0, dma_lat_i}) begin
      dma_done_o <= 1'b1;
      cnt <= cnt + 6'h01;
    end
    else if (cnt < {1'b0, dma_lat_i}) cnt <= cnt + 6'h01;
  end
endmodule : cws_ctl_model
`default_nettype wire

// ===== dv/cws_window_tb.sv
// Self-checking bench for the CPU to CAN register window
`timescale 1ns/1ps
`default_nettype none
`include "cws_map.svh"
module cws_window_tb;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_rd_i = 1'b0;
  logic       sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_bit_wr_i = 1'b0;
  logic [7:0] sfr_bit_addr_i = 8'h00;
  logic       sfr_bit_val_i = 1'b0;
  logic [4:0] ctl_int_i = 5'h00;
  logic [7:0] ctl_status_i = 8'h00;
  logic [4:0] dma_lat = 5'h00;
  logic [7:0] sfr_rdata_o, ctl_rdata_i, ctl_wdata_o, cmd_o, dma_ram_pointer_o;
  logic [4:0] ctl_sel_o, ctl_waddr_o, tx_end_o, rx_end_o;
  logic [3:0] tx_count_o, rx_count_o;
  logic       sfr_rvalid_o, ctl_rd_o, ctl_wr_o, cmd_wr_o, dma_done_i;
  logic       dma_start_o, dma_autostep_o, cmd_seen, ctl_seen, rd_seen;
  int         failures = 0;
  int         num_checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  cws_window dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_addr_i(sfr_bit_addr_i),
    .sfr_bit_val_i(sfr_bit_val_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_rvalid_o(sfr_rvalid_o), .ctl_sel_o(ctl_sel_o),
    .ctl_rdata_i(ctl_rdata_i), .ctl_rd_o(ctl_rd_o), .ctl_wr_o(ctl_wr_o),
    .ctl_waddr_o(ctl_waddr_o), .ctl_wdata_o(ctl_wdata_o),
    .ctl_int_i(ctl_int_i), .ctl_status_i(ctl_status_i),
    .cmd_wr_o(cmd_wr_o), .cmd_o(cmd_o), .dma_start_o(dma_start_o),
    .dma_autostep_o(dma_autostep_o), .dma_ram_pointer_o(dma_ram_pointer_o),
    .dma_done_i(dma_done_i), .tx_count_o(tx_count_o),
    .rx_count_o(rx_count_o), .tx_end_o(tx_end_o), .rx_end_o(rx_end_o));
  cws_ctl_model model (
    .clk_sys_i(clk_sys_i), .sel_i(ctl_sel_o), .rdata_o(ctl_rdata_i),
    .wr_i(ctl_wr_o), .waddr_i(ctl_waddr_o), .wdata_i(ctl_wdata_o),
    .dma_start_i(dma_start_o), .dma_lat_i(dma_lat),
    .dma_done_o(dma_done_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobes rise at a falling edge and drop one cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
    cmd_seen = cmd_wr_o;
    ctl_seen = ctl_wr_o;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    rd_seen = ctl_rd_o;
    chk({7'h0, sfr_rvalid_o}, 8'h01);
    chk(sfr_rdata_o, exp);
  endtask : rd
  task automatic bw(input logic [7:0] a, input logic v);
    @(negedge clk_sys_i);
    sfr_bit_addr_i = a;
    sfr_bit_val_i = v;
    sfr_bit_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_bit_wr_i = 1'b0;
  endtask : bw
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Whole run is about 120 cycles; this limit is far beyond it
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    int n;
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(`CWS_ADR_PTR, 8'h64);
    chk({3'h0, ctl_sel_o}, 8'h04);
    chk({7'h0, dma_autostep_o}, 8'h01);
    $display("test reset done");
    wr(`CWS_ADR_PTR, 8'h2a);
    wr(`CWS_ADR_DAT, 8'h81);
    // Second descriptor byte: data frame, three bytes
    wr(`CWS_ADR_DAT, 8'h23);
    for (int i = 0; i < 3; i++) begin
      wr(`CWS_ADR_DAT, 8'h11 * 8'(i + 1));
      chk({3'h0, ctl_waddr_o}, 8'd12 + 8'(i));
      chk({7'h0, ctl_seen}, 8'h01);
    end
    repeat (2) @(negedge clk_sys_i);
    chk(model.mem[12], 8'h11);
    chk({4'h0, tx_count_o}, 8'h03);
    chk({3'h0, tx_end_o}, 8'd15);
    rd(`CWS_ADR_PTR, 8'h6f);
    wr(`CWS_ADR_PTR, 8'h0c);
    rd(`CWS_ADR_DAT, 8'h11);
    chk({7'h0, rd_seen}, 8'h01);
    rd(`CWS_ADR_PTR, 8'h4c);
    $display("test transmit buffer done");
    wr(`CWS_ADR_PTR, 8'h35);
    wr(`CWS_ADR_DAT, 8'h1f);
    repeat (2) @(negedge clk_sys_i);
    chk({4'h0, rx_count_o}, 8'h00);
    chk({3'h0, rx_end_o}, 8'd22);
    wr(`CWS_ADR_PTR, 8'h35);
    wr(`CWS_ADR_DAT, 8'h08);
    repeat (2) @(negedge clk_sys_i);
    chk({4'h0, rx_count_o}, 8'h08);
    chk({3'h0, rx_end_o}, 8'd30);
    $display("test receive buffer done");
    wr(`CWS_ADR_PTR, 8'h3f);
    wr(`CWS_ADR_DAT, 8'h99);
    // The model stores on the edge after the forwarded strobe
    @(negedge clk_sys_i);
    chk(model.mem[31], 8'h99);
    rd(`CWS_ADR_PTR, 8'h40);
    $display("test pointer wrap done");
    ctl_int_i = 5'h15;
    rd(`CWS_ADR_CON, 8'hf5);
    ctl_int_i = 5'h0a;
    rd(`CWS_ADR_CON, 8'hea);
    for (int i = 0; i < 8; i++) begin
      wr(`CWS_ADR_CON, 8'h01 << i);
      chk(cmd_o, 8'h01 << i);
      chk({7'h0, cmd_seen}, 8'h01);
    end
    $display("test command port done");
    ctl_status_i = 8'ha5;
    rd(`CWS_ADR_STA, 8'ha5);
    // Plain writes only, never a value read back and modified
    wr(`CWS_ADR_STA, 8'h5a);
    chk(dma_ram_pointer_o, 8'h5a);
    bw(`CWS_BIT_TOP, 1'b1);
    chk(dma_ram_pointer_o, 8'hda);
    bw(`CWS_BIT_BASE, 1'b1);
    chk(dma_ram_pointer_o, 8'hdb);
    bw(8'hd9, 1'b0);
    chk(dma_ram_pointer_o, 8'hd9);
    $display("test status register done");
    rd(8'h80, 8'hff);
    wr(8'h80, 8'h00);
    rd(`CWS_ADR_PTR, 8'h40);
    $display("test unmapped done");
    // Pointer write and read in adjacent cycles
    @(negedge clk_sys_i);
    sfr_addr_i = `CWS_ADR_PTR;
    sfr_wdata_i = 8'h0b;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    chk(sfr_rdata_o, 8'h4b);
    $display("test back to back done");
    for (int k = 0; k < 2; k++) begin
      dma_lat = (k == 0) ? 5'h00 : 5'h09;
      wr(`CWS_ADR_PTR, 8'h8a);
      chk({7'h0, dma_start_o}, 8'h01);
      for (n = 0; n < 40 && dma_start_o !== 1'b0; n++) @(negedge clk_sys_i);
      rd(`CWS_ADR_PTR, 8'h4a);
    end
    $display("test dma start done");
    close_out();
  end
endmodule : cws_window_tb
`default_nettype wire
